// ### hpss_top.sv
// hpss_top: haptic playback setup sequencer, register file and playback engine
// assumes serial bus, enable and trigger pins arrive asynchronously;
// analog_level comes from a converter on the core clock
//
// Summary of operation
// RULE1 - host waits 250 us before bus traffic
// RULE2 - host raises enable during or after wait
// RULE3 - writing 0x00 to 0x01 leaves standby
// RULE4 - host skips or performs calibration as needed
// RULE5 - host loads waveform memory via 0xFD-0xFF
// RULE6 - reset gives closed-loop bidirectional; 0x1B-0x1D configure
// RULE7 - standby bit or enable low means low power
// RULE8 - codes 0,1,2 select memory playback triggers
// RULE9 - code 3 drives from PWM or analog
// RULE10 - code 5 drives from host amplitude writes
// RULE11 - index at 0x04, sequence in 0x04-0x0B
// RULE12 - fire bit at 0x0C starts internal playback
// RULE13 - trigger pin pulse starts external-trigger playback
// RULE14 - repeated fire replays without reloading indices
// RULE15 - amplitude written at 0x02 becomes drive
// RULE16 - 0x1D selects PWM or analog input
// RULE17 - host may skip redundant operation-select write
// RULE18 - trigger pin may be grounded if unused
// RULE19 - trigger pulse launches effect without bus traffic
// RULE20 - memory data write stores and increments pointer
// RULE21 - low power ignores fires, leaves outputs undriven
`timescale 1ns/1ps
`default_nettype none
module hpss_top #(
  parameter int POWERUP_CYCLES = hpss_pkg::POWERUP_CYC, // bus quiet time after power-up
  parameter int STEP_CYCLES = hpss_pkg::STEP_CYC // duration of one waveform step
) (
  input wire logic clk, // 25 MHz core clock
  input wire logic reset_n, // power-up reset, active low
  input wire logic scl_pin, // serial bus clock
  input wire logic sda_pin_in, // serial bus data, level seen
  output logic sda_pin_out, // serial bus data, driven value
  output logic sda_pin_oe_n, // low while pulling data line
  input wire logic enable_pin, // device enable, active high
  input wire logic trigger_input_pin, // trigger or PWM input
  input wire logic [7:0] analog_level, // converted analog input
  output logic [7:0] drive_amp, // actuator drive amplitude
  output logic drive_active, // actuator outputs driven
  output logic drive_bidir, // bidirectional drive selected
  output logic drive_open_loop, // open-loop drive selected
  output logic playing // memory playback running
);
  import hpss_pkg::*;

  typedef enum logic {P_IDLE, P_PLAY} hpss_play_e;

  ////////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic rst_meta, rst_n_int;
  logic [3:0] pin_raw, pin_meta, pin_sync;
  logic scl_s, sda_s, en_s, trig_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n_int <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_int <= rst_meta;
    end
  end

  assign pin_raw = {trigger_input_pin, enable_pin, sda_pin_in, scl_pin};

  generate
    for (genvar g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
          pin_meta[g] <= PIN_IDLE[g];
          pin_sync[g] <= PIN_IDLE[g];
        end else begin
          pin_meta[g] <= pin_raw[g];
          pin_sync[g] <= pin_meta[g];
        end
      end
    end
  endgenerate

  assign scl_s = pin_sync[0];
  assign sda_s = pin_sync[1];
  assign en_s = pin_sync[2];
  assign trig_s = pin_sync[3];

  ////////////////////////////////////////////////////////////////////////////////
  // power-up quiet time
  logic [12:0] up_cnt;
  logic bus_ready;

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      up_cnt <= 13'h0000;
      bus_ready <= 1'b0;
    end else if (!bus_ready) begin
      up_cnt <= up_cnt + 13'h0001;
      if (up_cnt == 13'(POWERUP_CYCLES - 1)) begin
        bus_ready <= 1'b1; // RULE1
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial bus slave and waveform memory
  logic [7:0] reg_ptr, wr_data, rd_data, ram_rd, wave_byte;
  logic wr_stb, ram_we;
  logic [7:0] opsel_reg, rtp_reg, cfg1_reg, cfg2_reg, cfg3_reg;
  logic [7:0] ptr_hi_reg, ptr_lo_reg;
  logic [7:0] slot_reg [SLOTS];
  logic fire_reg;
  logic [2:0] slot_sel;
  logic [3:0] step;
  logic [7:0] cur_idx;

  hpss_i2c_slave u_bus (
    .clk(clk),
    .rst_n(rst_n_int),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .accept(bus_ready),
    .rd_data(rd_data),
    .reg_ptr(reg_ptr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .sda_out(sda_pin_out),
    .sda_oe_n(sda_pin_oe_n)
  );

  assign ram_we = wr_stb && reg_ptr == A_RAM_DATA; // RULE20
  assign cur_idx = slot_reg[slot_sel];

  hpss_wave_ram u_ram (
    .clk(clk),
    .we(ram_we),
    .waddr({ptr_hi_reg[RAM_AW-9:0], ptr_lo_reg}),
    .wdata(wr_data),
    .raddr_a({ptr_hi_reg[RAM_AW-9:0], ptr_lo_reg}),
    .rdata_a(ram_rd),
    .raddr_b({cur_idx[RAM_AW-5:0], step}),
    .rdata_b(wave_byte)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [2:0] mode;
  logic active;

  assign mode = opsel_reg[2:0];
  assign active = en_s & ~opsel_reg[STANDBY_BIT]; // RULE7

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      opsel_reg <= OPSEL_RST; // RULE3
      rtp_reg <= 8'h00;
      cfg1_reg <= CFG1_RST; // RULE6
      cfg2_reg <= CFG2_RST;
      cfg3_reg <= CFG3_RST;
    end else if (wr_stb) begin
      case (reg_ptr)
        A_OPSEL: opsel_reg <= wr_data; // RULE3 RULE7
        A_RTP: rtp_reg <= wr_data; // RULE15
        A_CFG1: cfg1_reg <= wr_data; // RULE6
        A_CFG2: cfg2_reg <= wr_data;
        A_CFG3: cfg3_reg <= wr_data; // RULE16
        default: ;
      endcase
    end
  end

  // memory pointer, carries from low into high byte
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      ptr_hi_reg <= 8'h00;
      ptr_lo_reg <= 8'h00;
    end else if (ram_we) begin
      {ptr_hi_reg, ptr_lo_reg} <= {ptr_hi_reg, ptr_lo_reg} + 16'h0001; // RULE20
    end else if (wr_stb && reg_ptr == A_PTR_HI) begin
      ptr_hi_reg <= wr_data;
    end else if (wr_stb && reg_ptr == A_PTR_LO) begin
      ptr_lo_reg <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_reg[i] <= 8'h00;
      end
    end else if (wr_stb && reg_ptr >= A_SLOT0 && reg_ptr <= A_SLOT7) begin
      slot_reg[3'(reg_ptr - A_SLOT0)] <= wr_data; // RULE11
    end
  end

  always_comb begin
    rd_data = 8'h00;
    case (reg_ptr)
      A_OPSEL: rd_data = opsel_reg;
      A_RTP: rd_data = rtp_reg;
      A_FIRE: rd_data = {7'h00, fire_reg};
      A_CFG1: rd_data = cfg1_reg;
      A_CFG2: rd_data = cfg2_reg;
      A_CFG3: rd_data = cfg3_reg;
      A_PTR_HI: rd_data = ptr_hi_reg;
      A_PTR_LO: rd_data = ptr_lo_reg;
      A_RAM_DATA: rd_data = ram_rd;
      default: begin
        if (reg_ptr >= A_SLOT0 && reg_ptr <= A_SLOT7) begin
          rd_data = slot_reg[3'(reg_ptr - A_SLOT0)];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // playback engine
  hpss_play_e pstate;
  logic trig_d, trig_rise, mem_mode, start_req, stop_req, play_done, tick;
  logic [16:0] tick_cnt;

  assign trig_rise = trig_s & ~trig_d;
  assign mem_mode = mode == M_INT || mode == M_EDGE || mode == M_LEVEL; // RULE8
  assign tick = tick_cnt == 17'(STEP_CYCLES - 1);

  // fire only counts while awake
  assign start_req = active &&
                     ((mode == M_INT && fire_reg && pstate == P_IDLE) || // RULE12 RULE14
                      ((mode == M_EDGE || mode == M_LEVEL) && trig_rise)); // RULE13 RULE19 RULE21
  assign stop_req = !active || !mem_mode || (mode == M_INT && !fire_reg) ||
                    (mode == M_LEVEL && !trig_s); // RULE21
  assign play_done = pstate == P_PLAY && !stop_req && !start_req &&
                     (cur_idx == 8'h00 ||
                      (tick && (step == LAST_STEP || wave_byte == 8'h00) &&
                       (slot_sel == LAST_SLOT || slot_reg[slot_sel + 3'h1] == 8'h00)));

  // a host write lands even in the cycle playback ends
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      fire_reg <= 1'b0;
    end else if (wr_stb && reg_ptr == A_FIRE && active && mode == M_INT) begin
      fire_reg <= wr_data[FIRE_BIT]; // RULE12 RULE21
    end else if (play_done || !active) begin
      fire_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      trig_d <= 1'b0;
    end else begin
      trig_d <= trig_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pstate <= P_IDLE;
      slot_sel <= 3'h0;
      step <= 4'h0;
      tick_cnt <= 17'h0_0000;
    end else if (stop_req || play_done) begin
      pstate <= P_IDLE;
    end else if (start_req) begin
      pstate <= P_PLAY; // RULE14
      slot_sel <= 3'h0;
      step <= 4'h0;
      tick_cnt <= 17'h0_0000;
    end else if (pstate == P_PLAY) begin
      tick_cnt <= tick ? 17'h0_0000 : tick_cnt + 17'h0_0001;
      if (tick) begin
        if (step == LAST_STEP || wave_byte == 8'h00) begin
          slot_sel <= slot_sel + 3'h1; // RULE11
          step <= 4'h0;
        end else begin
          step <= step + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // duty measurement of the shared trigger pin
  logic [7:0] pwm_win, pwm_hi, pwm_level;

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pwm_win <= 8'h00;
      pwm_hi <= 8'h00;
      pwm_level <= 8'h00;
    end else if (pwm_win == PWM_WIN_END) begin
      pwm_win <= 8'h00;
      pwm_hi <= 8'h00;
      pwm_level <= pwm_hi + {7'h00, trig_s};
    end else begin
      pwm_win <= pwm_win + 8'h01;
      pwm_hi <= pwm_hi + {7'h00, trig_s};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // drive selection
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      drive_amp <= 8'h00;
      drive_active <= 1'b0;
      playing <= 1'b0;
    end else begin
      drive_amp <= 8'h00;
      drive_active <= 1'b0; // RULE21
      playing <= pstate == P_PLAY;
      if (active) begin
        case (mode)
          M_INT, M_EDGE, M_LEVEL: begin
            if (pstate == P_PLAY && cur_idx != 8'h00) begin
              drive_active <= 1'b1; // RULE8
              drive_amp <= wave_byte;
            end
          end
          M_EXT_IN: begin
            drive_active <= 1'b1; // RULE9
            drive_amp <= cfg3_reg[CFG3_ANALOG_BIT] ? analog_level : pwm_level; // RULE16
          end
          M_RTP: begin
            drive_active <= 1'b1; // RULE10
            drive_amp <= rtp_reg; // RULE15
          end
          default: ;
        endcase
      end
    end
  end

  assign drive_bidir = cfg2_reg[CFG2_BIDIR_BIT]; // RULE6
  assign drive_open_loop = cfg3_reg[CFG3_OPEN_LOOP_BIT];
endmodule : hpss_top
`default_nettype wire

// ### hpss_pkg.sv
// hpss_pkg: constants shared by the haptic playback setup sequencer
// assumes a 25 MHz core clock and an 8-bit register space behind the serial bus
package hpss_pkg;
  localparam int CLK_MHZ = 25;
  localparam int POWERUP_US = 250;
  localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
  localparam int STEP_US = 5000;
  localparam int STEP_CYC = STEP_US * CLK_MHZ;
  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] A_OPSEL = 8'h01;
  localparam logic [7:0] A_RTP = 8'h02;
  localparam logic [7:0] A_SLOT0 = 8'h04;
  localparam logic [7:0] A_SLOT7 = 8'h0B;
  localparam logic [7:0] A_FIRE = 8'h0C;
  localparam logic [7:0] A_CFG1 = 8'h1B;
  localparam logic [7:0] A_CFG2 = 8'h1C;
  localparam logic [7:0] A_CFG3 = 8'h1D;
  localparam logic [7:0] A_PTR_HI = 8'hFD;
  localparam logic [7:0] A_PTR_LO = 8'hFE;
  localparam logic [7:0] A_RAM_DATA = 8'hFF;
  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OPSEL_RST = 8'h40;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h80;
  localparam logic [7:0] CFG3_RST = 8'h00;
  localparam int STANDBY_BIT = 6;
  localparam int FIRE_BIT = 0;
  localparam int CFG2_BIDIR_BIT = 7;
  localparam int CFG3_ANALOG_BIT = 1;
  localparam int CFG3_OPEN_LOOP_BIT = 0;
  localparam logic [2:0] M_INT = 3'h0;
  localparam logic [2:0] M_EDGE = 3'h1;
  localparam logic [2:0] M_LEVEL = 3'h2;
  localparam logic [2:0] M_EXT_IN = 3'h3;
  localparam logic [2:0] M_RTP = 3'h5;
  ////////////////////////////////////////////////////////////////////////////////
  localparam int RAM_AW = 11;
  localparam int RAM_DEPTH = 2048;
  localparam int SLOTS = 8;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [3:0] LAST_STEP = 4'hF;
  localparam logic [7:0] PWM_WIN_END = 8'hFE;
  localparam logic [3:0] PIN_IDLE = 4'h3;
endpackage : hpss_pkg

// ### hpss_wave_ram.sv
// hpss_wave_ram: waveform byte store, one write port, two read ports
// assumes a single clock; reads are combinational
`timescale 1ns/1ps
`default_nettype none
module hpss_wave_ram (
  input wire logic clk, // core clock
  input wire logic we, // byte write
  input wire logic [hpss_pkg::RAM_AW-1:0] waddr, // write address
  input wire logic [7:0] wdata, // write byte
  input wire logic [hpss_pkg::RAM_AW-1:0] raddr_a, // register read address
  output logic [7:0] rdata_a, // register read byte
  input wire logic [hpss_pkg::RAM_AW-1:0] raddr_b, // playback read address
  output logic [7:0] rdata_b // playback read byte
);
  import hpss_pkg::*;

  logic [7:0] mem [RAM_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule : hpss_wave_ram
`default_nettype wire

// ### hpss_i2c_slave.sv
// hpss_i2c_slave: two-wire serial register slave with address pointer
// assumes scl_s and sda_s already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module hpss_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2C // arbitrary value
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic scl_s, // synchronised clock line
  input wire logic sda_s, // synchronised data line
  input wire logic accept, // high once commands are accepted
  input wire logic [7:0] rd_data, // byte at reg_ptr
  output logic [7:0] reg_ptr, // register pointer
  output logic [7:0] wr_data, // written byte
  output logic wr_stb, // one-cycle write pulse
  output logic sda_out, // data line value when driven
  output logic sda_oe_n // low while pulling data line
);
  import hpss_pkg::*;

  typedef enum logic [2:0] {I_IDLE, I_DEV, I_REG, I_WR, I_RD} hpss_i2c_e;
  hpss_i2c_e state;
  logic scl_d, sda_d, ack_ph, rw;
  logic [3:0] bits;
  logic [7:0] shift;
  logic scl_rise, scl_fall, start_c, stop_c;

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= I_IDLE;
      ack_ph <= 1'b0;
      rw <= 1'b0;
      bits <= 4'h0;
      shift <= 8'h00;
      reg_ptr <= 8'h00;
      wr_data <= 8'h00;
      wr_stb <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        state <= I_DEV;
        bits <= 4'h0;
        ack_ph <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        state <= I_IDLE;
        ack_ph <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (state != I_IDLE) begin
        if (scl_rise) begin
          if (!ack_ph) begin
            bits <= bits + 4'h1;
            if (state != I_RD) begin
              shift <= {shift[6:0], sda_s};
            end
          end else if (state == I_RD && sda_s) begin
            state <= I_IDLE; // master declined more data
          end
        end else if (scl_fall) begin
          if (ack_ph) begin
            ack_ph <= 1'b0;
            bits <= 4'h0;
            sda_oe_n <= 1'b1;
            case (state)
              I_DEV: begin
                if (rw) begin
                  state <= I_RD;
                  sda_oe_n <= rd_data[7];
                  shift <= {rd_data[6:0], 1'b0};
                end else begin
                  state <= I_REG;
                end
              end
              I_REG: state <= I_WR;
              I_WR: begin
                if (reg_ptr != A_RAM_DATA) begin
                  reg_ptr <= reg_ptr + 8'h01;
                end
              end
              I_RD: begin
                sda_oe_n <= rd_data[7];
                shift <= {rd_data[6:0], 1'b0};
              end
              default: state <= I_IDLE;
            endcase
          end else if (bits == 4'h8) begin
            ack_ph <= 1'b1;
            case (state)
              I_DEV: begin
                if (shift[7:1] == DEV_ADDR && accept) begin // RULE1
                  sda_oe_n <= 1'b0;
                  rw <= shift[0];
                end else begin
                  state <= I_IDLE;
                end
              end
              I_REG: begin
                reg_ptr <= shift;
                sda_oe_n <= 1'b0;
              end
              I_WR: begin
                wr_data <= shift;
                wr_stb <= 1'b1;
                sda_oe_n <= 1'b0;
              end
              default: begin
                sda_oe_n <= 1'b1;
                if (reg_ptr != A_RAM_DATA) begin
                  reg_ptr <= reg_ptr + 8'h01;
                end
              end
            endcase
          end else if (state == I_RD) begin
            sda_oe_n <= shift[7];
            shift <= {shift[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule : hpss_i2c_slave
`default_nettype wire

// ### hpss_props.sv
// hpss_props: pin-level timing checks on the playback sequencer
// assumes binding onto hpss_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module hpss_props #(
  parameter int POWERUP_CYCLES = 20 // bus quiet time
) (
  input wire logic clk, // core clock
  input wire logic reset_n, // reset, active low
  input wire logic scl_pin, // bus clock
  input wire logic sda_pin_out, // bus data driven
  input wire logic sda_pin_oe_n, // data enable, active low
  input wire logic enable_pin, // device enable
  input wire logic [7:0] drive_amp, // drive level
  input wire logic drive_active, // outputs driven
  input wire logic drive_bidir, // bidirectional drive
  input wire logic drive_open_loop, // open loop drive
  input wire logic playing // playback running
);
  int pu_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pu_cnt <= 0;
    end else if (pu_cnt < POWERUP_CYCLES) begin
      pu_cnt <= pu_cnt + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  sequence s_disabled;
    !enable_pin [*6];
  endsequence
  chk_idle_amp_zero: assert property (!drive_active |-> drive_amp == 8'h00)
    else $error("drive level nonzero while undriven");
  chk_off_no_drive: assert property (s_disabled |-> !drive_active)
    else $error("outputs driven with enable low");
  chk_off_no_play: assert property (s_disabled |-> !playing)
    else $error("playback running with enable low");
  chk_reset_drive_cfg: assert property ($rose(reset_n) |-> drive_bidir && !drive_open_loop)
    else $error("drive setup wrong out of reset");
  chk_reset_outputs: assert property ($rose(reset_n) |-> !drive_active && !playing)
    else $error("outputs active out of reset");
  chk_powerup_quiet: assert property (pu_cnt < POWERUP_CYCLES |-> sda_pin_oe_n)
    else $error("bus answered before power-up time");
  chk_sda_pull_low: assert property (!sda_pin_oe_n |-> !sda_pin_out)
    else $error("data line driven high");
  chk_sda_scl_low: assert property ($changed(sda_pin_oe_n) |-> !scl_pin)
    else $error("data line changed while clock high");
endmodule : hpss_props
bind hpss_top hpss_props #(.POWERUP_CYCLES(POWERUP_CYCLES)) hpss_props_inst (
  .clk(clk), .reset_n(reset_n), .scl_pin(scl_pin), .sda_pin_out(sda_pin_out),
  .sda_pin_oe_n(sda_pin_oe_n), .enable_pin(enable_pin), .drive_amp(drive_amp),
  .drive_active(drive_active), .drive_bidir(drive_bidir),
  .drive_open_loop(drive_open_loop), .playing(playing)
);
`default_nettype wire

// ### hpss_host_model.sv
// hpss_host_model: serial bus master standing in for the host
// assumes a pulled-up data wire whose level returns on sda_w
`timescale 1ns/1ps
`default_nettype none
module hpss_host_model (
  input wire logic clk, // core clock
  input wire logic sda_w, // data wire level
  output logic scl, // bus clock
  output logic sda // data drive, 1 releases
);
  localparam logic [6:0] DEV = 7'h2C; // arbitrary value, slave default
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic ph(input int n);
    repeat (n) @(negedge clk);
  endtask : ph
  // data moves only while clock low, sampled at end of high phase
  task automatic bit1(input logic b, output logic r);
    ph(2);
    sda = b;
    ph(8);
    scl = 1'b1;
    ph(8);
    r = sda_w;
    scl = 1'b0;
  endtask : bit1
  task automatic byte8(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], r);
      q[i] = r;
    end
    bit1(1'b1, r);
    ack = !r;
  endtask : byte8
  task automatic start;
    sda = 1'b1;
    ph(8);
    scl = 1'b1;
    ph(8);
    sda = 1'b0;
    ph(8);
    scl = 1'b0;
  endtask : start
  task automatic stop;
    ph(2);
    sda = 1'b0;
    ph(8);
    scl = 1'b1;
    ph(8);
    sda = 1'b1;
    ph(8);
  endtask : stop
  task automatic wr(input logic [7:0] a, input logic [7:0] d[6], input int n,
                    output logic ok);
    logic [7:0] q;
    logic k;
    start;
    byte8({DEV, 1'b0}, q, ok);
    byte8(a, q, k);
    ok = ok & k;
    for (int i = 0; i < n; i++) begin
      byte8(d[i], q, k);
      ok = ok & k;
    end
    stop;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic k;
    start;
    byte8({DEV, 1'b0}, q, k);
    byte8(a, q, k);
    start;
    byte8({DEV, 1'b1}, q, k);
    byte8(8'hFF, q, k);
    stop;
  endtask : rd
endmodule : hpss_host_model
`default_nettype wire

// ### hpss_top_tb_top.sv
// hpss_top_tb_top: register-level playback tests of the sequencer
// assumes hpss_host_model on the bus and hpss_props bound in
`timescale 1ns/1ps
`default_nettype none
module hpss_top_tb_top;
  import hpss_pkg::*;
  localparam int PU = 20;
  localparam int ST = 64;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic en = 1'b0;
  logic trg = 1'b0;
  logic scl, hsda, sda_pin_out, sda_pin_oe_n;
  logic drive_active, drive_bidir, drive_open_loop, playing, play_q;
  logic [7:0] drive_amp;
  logic [7:0] amp_or = 8'h00;
  int n_mismatch = 0;
  int checked = 0;
  int starts = 0;
  wire sda_w = hsda & (sda_pin_oe_n | sda_pin_out);
  initial begin
    forever #20 clk = ~clk;
  end
  hpss_top #(.POWERUP_CYCLES(PU), .STEP_CYCLES(ST)) hpss_top_inst (
    .clk(clk), .reset_n(reset_n), .scl_pin(scl), .sda_pin_in(sda_w),
    .sda_pin_out(sda_pin_out), .sda_pin_oe_n(sda_pin_oe_n), .enable_pin(en),
    .trigger_input_pin(trg), .analog_level(8'h77), .drive_amp(drive_amp),
    .drive_active(drive_active), .drive_bidir(drive_bidir),
    .drive_open_loop(drive_open_loop), .playing(playing)
  );
  hpss_host_model hpss_host_model_inst (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(hsda));
  // counts playback launches and collects driven levels
  always @(posedge clk) begin
    play_q <= playing;
    if (playing === 1'b1 && play_q !== 1'b1) starts <= starts + 1;
    if (drive_active === 1'b1) amp_or <= amp_or | drive_amp;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, input logic [7:0] d[6], input int n);
    logic ok;
    hpss_host_model_inst.wr(a, d, n, ok);
    chk({7'h00, ok}, 8'h01);
  endtask : w
  task automatic w1(input logic [7:0] a, input logic [7:0] d);
    w(a, '{d, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
  endtask : w1
  task automatic r1(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    hpss_host_model_inst.rd(a, q);
    chk(q, e);
  endtask : r1
  task automatic wait_idle;
    for (int i = 0; i < 1000 && playing !== 1'b0; i++) @(negedge clk);
  endtask : wait_idle
  task automatic print_verdict;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  ////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clk);
    chk({6'h00, drive_bidir, drive_open_loop}, 8'h02);
    reset_n = 1'b1;
    en = 1'b1;
    repeat (PU + 8) @(negedge clk);
    r1(A_OPSEL, OPSEL_RST);
    w1(A_OPSEL, 8'h00);
    r1(A_OPSEL, 8'h00);
    // no calibration store in this model, so calibration is skipped
    w(A_PTR_HI, '{8'h00, 8'h10, 8'h30, 8'h60, 8'h00, 8'h00}, 5);
    w(A_PTR_HI, '{8'h00, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
    r1(A_RAM_DATA, 8'h60);
    w(A_SLOT0, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
    w1(A_FIRE, 8'h01);
    wait_idle();
    chk(starts[7:0], 8'h01);
    chk(amp_or, 8'h70);
    r1(A_FIRE, 8'h00);
    w1(A_FIRE, 8'h01);
    wait_idle();
    chk(starts[7:0], 8'h02);
    w1(A_OPSEL, {5'h00, M_EDGE});
    trg = 1'b1;
    repeat (10) @(negedge clk);
    trg = 1'b0;
    wait_idle();
    chk(starts[7:0], 8'h03);
    w1(A_OPSEL, {5'h00, M_LEVEL});
    trg = 1'b1;
    repeat (20) @(negedge clk);
    chk({7'h00, playing}, 8'h01);
    trg = 1'b0;
    repeat (10) @(negedge clk);
    chk({7'h00, playing}, 8'h00);
    w(A_CFG1, '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00}, 3);
    w1(A_OPSEL, {5'h00, M_EXT_IN});
    repeat (10) @(negedge clk);
    chk(drive_amp, 8'h77);
    chk({6'h00, drive_bidir, drive_open_loop}, 8'h01);
    w1(A_CFG3, 8'h01);
    trg = 1'b1;
    repeat (600) @(negedge clk);
    chk(drive_amp, 8'hFF);
    trg = 1'b0;
    w1(A_OPSEL, {5'h00, M_RTP});
    w1(A_RTP, 8'h5A);
    chk(drive_amp, 8'h5A);
    w1(A_RTP, 8'hA5);
    chk(drive_amp, 8'hA5);
    w1(A_OPSEL, 8'h45);
    repeat (4) @(negedge clk);
    chk({7'h00, drive_active}, 8'h00);
    w1(A_OPSEL, 8'h00);
    en = 1'b0;
    repeat (8) @(negedge clk);
    w1(A_FIRE, 8'h01);
    repeat (20) @(negedge clk);
    chk(starts[7:0], 8'h04);
    r1(8'h30, 8'h00);
    print_verdict();
  end
endmodule : hpss_top_tb_top
`default_nettype wire
